// ---- rtl/dpr_map.vh ----
// Constants for the DVI pixel output router
`ifndef DPR_MAP_VH
`define DPR_MAP_VH
`define DPR_PIX_W 24
`define DPR_LANE_W 8
`define DPR_BLUE_LO 0
`define DPR_GREEN_LO 8
`define DPR_RED_LO 16
`define DPR_FIFO_DEPTH 8
`define DPR_FIFO_AW 3
// FIFO word: de, hsync, vsync, aux1..3, red, green, blue
`define DPR_WORD_W 30
`define DPR_W_DE 29
`define DPR_W_HS 28
`define DPR_W_VS 27
`define DPR_W_A1 26
`define DPR_W_A2 25
`define DPR_W_A3 24
`define DPR_DIV_HALF 2
`endif

// ---- rtl/dpr_fifo.v ----
// Parameterised FIFO with valid/ready on both sides and registered read data
`timescale 1ns/10ps
module dpr_fifo #(
  parameter WIDTH = 30,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rstn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid_ff,
  input wire outReady,
  output reg [WIDTH-1:0] outData_ff
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doWr;
  wire doRd;
  wire needOut;

  // ----------------------------------------
  // Flags and handshakes
  // ----------------------------------------
  assign inReady = (count_ff != DEPTH[AW:0]);
  assign needOut = !outValid_ff || outReady;
  assign doRd = needOut && (count_ff != {(AW+1){1'b0}});
  assign doWr = inValid && inReady;

  // Storage array, no reset needed on data
  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Pointers, count and output register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      outValid_ff <= 1'b0;
      outData_ff <= {WIDTH{1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ?
          {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ?
          {AW{1'b0}} : rdPtr_ff + 1'b1;
        outData_ff <= mem[rdPtr_ff];
      end
      if (needOut) begin
        outValid_ff <= doRd;
      end
      count_ff <= count_ff + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
    end
  end
endmodule // dpr_fifo

// ---- rtl/dpr_router.v ----
// DVI pixel output router: decoded link words to even/odd pixel buses
`timescale 1ns/10ps
`include "dpr_map.vh"
// ----------------------------------------
// Operation overview
// ----------------------------------------
// Every link input is asynchronous to sys_clk, so the reference clock
// and all channel words pass two flip-flops first. A third flop on the
// reference clock finds its rising edge; at that edge the synchronised
// word is taken. Data lines settle a cycle before the clock rises, so
// the two-flop data copy is steady when the edge is seen.
// The captured word is split by data enable: pixel lanes in active
// display, sync and aux bits in blanking. Unused lanes go to zero so a
// blanking word never leaks stale colour onto the buses.
// An eight-word buffer decouples link rate from output tick rate. When
// full, link words are lost; linkReady goes low a cycle later to show
// it, since it is a flopped copy of the buffer's own ready.
// The output clock is sys_clk/4 from a free-running divider. All bus
// and control outputs change on the sys_clk edge where it falls, so a
// panel latching on its rise sees values a half period old.
// Two-pixel mode pairs words: the first active word of a line is even
// and waits in evenHold_ff; the next active word completes the pair.
// An empty buffer at a tick shows DE low but keeps a held even pixel,
// so a slow link does not tear pairs apart.
// A blanking word drops any unpaired even pixel and restarts pairing.
// Limitation: the width select is sampled only at output ticks, so a
// change mid-pair takes effect on the following pixel.
module dpr_router #(
  parameter PIX_W = `DPR_PIX_W,
  parameter DEPTH = `DPR_FIFO_DEPTH
) (
  input wire sys_clk,
  input wire rstn,
  input wire linkRefClk,
  input wire linkDe,
  input wire [7:0] linkChannelBlue,
  input wire [7:0] linkChannelGreen,
  input wire [7:0] linkChannelRed,
  input wire [1:0] linkCtlBlue,
  input wire [1:0] linkCtlGreen,
  input wire [1:0] linkCtlRed,
  input wire pixelWidthSelect,
  output wire linkReady,
  output reg outputDataClock_ff,
  output reg [PIX_W-1:0] evenPixelBus_ff,
  output reg [PIX_W-1:0] oddPixelBus_ff,
  output reg dataEnable_ff,
  output reg hsync_ff,
  output reg vsync_ff,
  output reg auxControlOne_ff,
  output reg auxControlTwo_ff,
  output reg auxControlThree_ff
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg clkS1_ff, clkS2_ff, clkS3_ff;
  reg deS1_ff, deS2_ff;
  reg [7:0] bS1_ff, bS2_ff, gS1_ff, gS2_ff, rS1_ff, rS2_ff;
  reg [1:0] cbS1_ff, cbS2_ff, cgS1_ff, cgS2_ff, crS1_ff, crS2_ff;
  reg pixS1_ff, pixS2_ff;
  wire refRise;

  // Two stages on every off-domain input, link clock included
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkS1_ff <= 1'b0;
      clkS2_ff <= 1'b0;
      clkS3_ff <= 1'b0;
      deS1_ff <= 1'b0;
      deS2_ff <= 1'b0;
      bS1_ff <= 8'h00;
      bS2_ff <= 8'h00;
      gS1_ff <= 8'h00;
      gS2_ff <= 8'h00;
      rS1_ff <= 8'h00;
      rS2_ff <= 8'h00;
      cbS1_ff <= 2'h0;
      cbS2_ff <= 2'h0;
      cgS1_ff <= 2'h0;
      cgS2_ff <= 2'h0;
      crS1_ff <= 2'h0;
      crS2_ff <= 2'h0;
      pixS1_ff <= 1'b0;
      pixS2_ff <= 1'b0;
    end else begin
      clkS1_ff <= linkRefClk;
      clkS2_ff <= clkS1_ff;
      clkS3_ff <= clkS2_ff;
      deS1_ff <= linkDe;
      deS2_ff <= deS1_ff;
      bS1_ff <= linkChannelBlue;
      bS2_ff <= bS1_ff;
      gS1_ff <= linkChannelGreen;
      gS2_ff <= gS1_ff;
      rS1_ff <= linkChannelRed;
      rS2_ff <= rS1_ff;
      cbS1_ff <= linkCtlBlue;
      cbS2_ff <= cbS1_ff;
      cgS1_ff <= linkCtlGreen;
      cgS2_ff <= cgS1_ff;
      crS1_ff <= linkCtlRed;
      crS2_ff <= crS1_ff;
      pixS1_ff <= pixelWidthSelect;
      pixS2_ff <= pixS1_ff;
    end
  end

  // Capture on a rising reference edge seen in the system domain
  assign refRise = clkS2_ff && !clkS3_ff;

  // ----------------------------------------
  // Channel decode into FIFO words
  // ----------------------------------------
  wire [`DPR_WORD_W-1:0] capWord;
  wire fifoValid;
  wire fifoInReady;
  reg linkReady_ff;

  // Colour lane passes only in active display
  function [7:0] gateLane;
    input keep;
    input [7:0] lane;
    begin
      gateLane = keep ? lane : 8'h00;
    end
  endfunction

  // Control bit passes only in blanking
  function gateCtl;
    input de;
    input bit0;
    begin
      gateCtl = de ? 1'b0 : bit0;
    end
  endfunction
  wire [`DPR_WORD_W-1:0] fifoWord;
  reg popReq;

  // Data enable picks pixel lanes or control bits
  assign capWord = {deS2_ff,
                    gateCtl(deS2_ff, cbS2_ff[0]),
                    gateCtl(deS2_ff, cbS2_ff[1]),
                    gateCtl(deS2_ff, cgS2_ff[0]),
                    gateCtl(deS2_ff, crS2_ff[0]),
                    gateCtl(deS2_ff, crS2_ff[1]),
                    gateLane(deS2_ff, rS2_ff),
                    gateLane(deS2_ff, gS2_ff),
                    gateLane(deS2_ff, bS2_ff)};

  // Eight-word buffer absorbs link/output rate mismatch;
  // a full buffer drops link words, flagged by linkReady low
  dpr_fifo #(
    .WIDTH(`DPR_WORD_W),
    .DEPTH(DEPTH),
    .AW(`DPR_FIFO_AW)
  ) uFifo (
    .clk(sys_clk),
    .rstn(rstn),
    .inValid(refRise),
    .inReady(fifoInReady),
    .inData(capWord),
    .outValid_ff(fifoValid),
    .outReady(popReq),
    .outData_ff(fifoWord)
  );

  // Ready status from a flop; one cycle late, status only
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      linkReady_ff <= 1'b1;
    end else begin
      linkReady_ff <= fifoInReady;
    end
  end
  assign linkReady = linkReady_ff;

  // ----------------------------------------
  // Output clock divider and pixel assembly
  // ----------------------------------------
  localparam ST_EVEN = 1'b0;
  localparam ST_ODD = 1'b1;
  reg [1:0] divCnt_ff;
  reg state_ff;
  reg [PIX_W-1:0] evenHold_ff;
  reg twoMode_ff;
  wire odckFall;
  wire [PIX_W-1:0] fifoPix;

  assign fifoPix = fifoWord[PIX_W-1:0];
  // Outputs update where the output clock falls, so rising edge latches
  assign odckFall = outputDataClock_ff &&
    (divCnt_ff == `DPR_DIV_HALF - 1);

  // Pop one word per output tick; two when an active even word is grabbed early in two-pixel mode
  always @* begin
    popReq = 1'b0;
    if (odckFall) begin
      popReq = 1'b1;
    end else if (twoMode_ff && state_ff == ST_EVEN &&
      divCnt_ff == 2'h0 && fifoValid && fifoWord[`DPR_W_DE]) begin
      popReq = 1'b1;
    end
  end

  // Output clock divider, free running
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_ff <= 2'h0;
      outputDataClock_ff <= 1'b0;
    end else if (divCnt_ff == `DPR_DIV_HALF - 1) begin
      divCnt_ff <= 2'h0;
      outputDataClock_ff <= !outputDataClock_ff;
    end else begin
      divCnt_ff <= divCnt_ff + 2'h1;
    end
  end

  // Pixel pairing and bus drive on the output clock tick; the early even grab in two-pixel mode comes before it
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_EVEN;
      evenHold_ff <= {PIX_W{1'b0}};
      twoMode_ff <= 1'b0;
      evenPixelBus_ff <= {PIX_W{1'b0}};
      oddPixelBus_ff <= {PIX_W{1'b0}};
      dataEnable_ff <= 1'b0;
      hsync_ff <= 1'b0;
      vsync_ff <= 1'b0;
      auxControlOne_ff <= 1'b0;
      auxControlTwo_ff <= 1'b0;
      auxControlThree_ff <= 1'b0;
    end else begin
      // Grab the even half early in two-pixel mode
      if (popReq && !odckFall) begin
        evenHold_ff <= fifoPix;
        state_ff <= ST_ODD;
      end
      if (odckFall) begin
        // Mode only changes at ticks to avoid torn pairs
        twoMode_ff <= pixS2_ff;
        if (fifoValid && !fifoWord[`DPR_W_DE]) begin
          // Blanking: control outputs, buses low
          state_ff <= ST_EVEN; // Next line restarts at pixel 0
          dataEnable_ff <= 1'b0;
          hsync_ff <= fifoWord[`DPR_W_HS];
          vsync_ff <= fifoWord[`DPR_W_VS];
          auxControlOne_ff <= fifoWord[`DPR_W_A1];
          auxControlTwo_ff <= fifoWord[`DPR_W_A2];
          auxControlThree_ff <= fifoWord[`DPR_W_A3];
          evenPixelBus_ff <= {PIX_W{1'b0}};
          oddPixelBus_ff <= {PIX_W{1'b0}};
        end else if (fifoValid) begin
          dataEnable_ff <= 1'b1;
          case (state_ff)
            ST_ODD: begin
              // Even pixel to even bus, odd pixel to odd bus
              evenPixelBus_ff <= evenHold_ff;
              oddPixelBus_ff <= fifoPix;
              state_ff <= ST_EVEN;
            end
            ST_EVEN: begin
              if (twoMode_ff) begin
                // Even half waits for its odd partner
                evenHold_ff <= fifoPix;
                state_ff <= ST_ODD;
                dataEnable_ff <= 1'b0;
                evenPixelBus_ff <= {PIX_W{1'b0}};
                oddPixelBus_ff <= {PIX_W{1'b0}};
              end else begin
                // Sequential pixels on even bus, odd bus low
                evenPixelBus_ff <= fifoPix;
                oddPixelBus_ff <= {PIX_W{1'b0}};
              end
            end
            default: begin
              state_ff <= ST_EVEN;
            end
          endcase
        end else begin
          // Underflow: drop DE, keep controls and any held even pixel
          dataEnable_ff <= 1'b0;
          evenPixelBus_ff <= {PIX_W{1'b0}};
          oddPixelBus_ff <= {PIX_W{1'b0}};
        end
      end
    end
  end
endmodule // dpr_router

// ---- test/dpr_router_checker.sv ----
// Timing and mapping checker for the pixel output router
`timescale 1ns/10ps
module dpr_router_checker #(
  parameter PIX_W = 24
) (
  input wire sys_clk,
  input wire rstn,
  input wire pixelWidthSelect,
  input wire outputDataClock_ff,
  input wire [PIX_W-1:0] evenPixelBus_ff,
  input wire [PIX_W-1:0] oddPixelBus_ff,
  input wire dataEnable_ff,
  input wire hsync_ff,
  input wire vsync_ff,
  input wire auxControlOne_ff,
  input wire auxControlTwo_ff,
  input wire auxControlThree_ff
);
  // ----------------------------------------
  // Helper logic and assertions
  // ----------------------------------------
  reg [3:0] oneModeCnt_ff;
  wire [4:0] ctlOut = {hsync_ff, vsync_ff, auxControlOne_ff,
    auxControlTwo_ff, auxControlThree_ff};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Saturates; sync plus tick wait needs well under 15 cycles
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn || pixelWidthSelect) oneModeCnt_ff <= 4'h0;
    else if (oneModeCnt_ff != 4'hF) oneModeCnt_ff <= oneModeCnt_ff + 4'h1;
  end
  a_output_data_clock_half: assert property (
    $rose(outputDataClock_ff) |=> outputDataClock_ff ##1 !outputDataClock_ff)
    else $error("output clock high phase wrong");
  a_even_on_fall: assert property (
    $changed(evenPixelBus_ff) |-> $fell(outputDataClock_ff))
    else $error("even bus moved off clock fall");
  a_odd_on_fall: assert property (
    $changed(oddPixelBus_ff) |-> $fell(outputDataClock_ff))
    else $error("odd bus moved off clock fall");
  a_ctl_on_fall: assert property (
    $changed({dataEnable_ff, ctlOut}) |-> $fell(outputDataClock_ff))
    else $error("control moved off clock fall");
  a_odd_one_low: assert property (
    oneModeCnt_ff == 4'hF |-> oddPixelBus_ff == 0)
    else $error("odd bus not low in one-pixel mode");
  a_blank_zero: assert property (
    !dataEnable_ff |-> evenPixelBus_ff == 0 && oddPixelBus_ff == 0)
    else $error("pixel bus set in blanking");
  a_ctl_hold_active: assert property (
    dataEnable_ff |-> $stable(ctlOut))
    else $error("control changed in active display");
  a_output_data_clock_low: assert property (
    $fell(outputDataClock_ff) |=> !outputDataClock_ff ##1 outputDataClock_ff)
    else $error("output clock low phase wrong");
endmodule // dpr_router_checker

bind dpr_router dpr_router_checker #(.PIX_W(PIX_W)) dpr_router_checker_inst (.*);

// ---- test/dpr_link_model.sv ----
// Link transmitter model: one decoded word per reference clock period
`timescale 1ns/10ps
module dpr_link_model (
  input wire sys_clk,
  output reg linkRefClk,
  output wire linkDe,
  output wire [7:0] linkChannelBlue,
  output wire [7:0] linkChannelGreen,
  output wire [7:0] linkChannelRed,
  output wire [1:0] linkCtlBlue,
  output wire [1:0] linkCtlGreen,
  output wire [1:0] linkCtlRed
);
  reg [30:0] linkWord = 31'h0;
  initial linkRefClk = 1'b0;
  // Pixel bytes in active display, control pairs in blanking
  assign {linkDe, linkChannelRed, linkChannelGreen, linkChannelBlue,
    linkCtlRed, linkCtlGreen, linkCtlBlue} = linkWord;
  // 160 ns period; data set a cycle ahead of the rise, held after it
  task automatic send(input logic [30:0] w);
    @(negedge sys_clk) linkWord = w;
    @(negedge sys_clk) linkRefClk = 1'b1;
    repeat (4) @(negedge sys_clk);
    linkRefClk = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // Clock stands still; stale data inverted so it cannot pass as valid
  task automatic idle();
    @(negedge sys_clk) linkWord = ~linkWord;
  endtask
endmodule // dpr_link_model

// ---- test/dpr_router_bench.sv ----
// Self-checking bench for the pixel output router
`timescale 1ns/10ps
module dpr_router_bench;
  logic sys_clk, rstn, pixelWidthSelect, haveEven;
  wire linkRefClk, linkDe, linkReady, outputDataClock_ff, dataEnable_ff;
  wire [7:0] linkChannelBlue, linkChannelGreen, linkChannelRed;
  wire [1:0] linkCtlBlue, linkCtlGreen, linkCtlRed;
  wire [23:0] evenPixelBus_ff, oddPixelBus_ff;
  wire hsync_ff, vsync_ff, auxControlOne_ff, auxControlTwo_ff;
  wire auxControlThree_ff;
  int failCount = 0;
  int totalChecks = 0;
  logic [47:0] seenQ[$], expQ[$];
  logic [23:0] heldPix;
  // Row: controls expected after it, de, pixel {r,g,b}, ctl {r,g,b}
  logic [35:0] rows [0:9] = '{
    {5'h00, 1'b0, 24'h0, 6'h2A}, {5'h00, 1'b1, 24'hC3A51E, 6'h0},
    {5'h00, 1'b1, 24'h5AF00F, 6'h0}, {5'h00, 1'b1, 24'h81247E, 6'h0},
    {5'h16, 1'b0, 24'h0, 6'h15}, {5'h00, 1'b0, 24'h0, 6'h15},
    {5'h00, 1'b1, 24'h3CFF00, 6'h0}, {5'h00, 1'b1, 24'h00017F, 6'h0},
    {5'h00, 1'b1, 24'hE718C9, 6'h0}, {5'h09, 1'b0, 24'h0, 6'h2A}};
  dpr_router dpr_router_inst (.*);
  dpr_link_model dpr_link_model_inst (.*);
  // ----------------------------------------
  // Clock, monitor and checking tasks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Panel side latches on the output clock rise
  always @(posedge outputDataClock_ff)
    if (dataEnable_ff === 1'b1) seenQ.push_back({evenPixelBus_ff,
      oddPixelBus_ff});
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic completeRun();
    if (failCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One line: blank, three pixels, blank; odd leftover must be dropped
  task automatic run_pass(input logic mode, input int first);
    pixelWidthSelect = mode;
    repeat (16) @(negedge sys_clk);
    seenQ = {};
    expQ = {};
    haveEven = 1'b0;
    for (int i = first; i < first + 5; i++) begin
      if (!rows[i][30]) haveEven = 1'b0;
      else if (!mode) expQ.push_back({rows[i][29:6], 24'h0});
      else if (haveEven) begin
        expQ.push_back({heldPix, rows[i][29:6]});
        haveEven = 1'b0;
      end else begin
        heldPix = rows[i][29:6];
        haveEven = 1'b1;
      end
      dpr_link_model_inst.send(rows[i][30:0]);
    end
    dpr_link_model_inst.idle();
    repeat (64) @(negedge sys_clk);
    check(seenQ.size(), expQ.size());
    foreach (expQ[k]) check(seenQ[k], expQ[k]);
    check({hsync_ff, vsync_ff, auxControlOne_ff, auxControlTwo_ff,
      auxControlThree_ff}, rows[first+4][35:31]);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    pixelWidthSelect = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    run_pass(1'b0, 0);
    run_pass(1'b1, 5);
    // Second reset after both passes: buses, DE, hsync and linkReady back to idle levels
    rstn = 1'b0;
    @(negedge sys_clk);
    check({evenPixelBus_ff, oddPixelBus_ff}, 48'h0);
    check({dataEnable_ff, hsync_ff, linkReady}, 48'h1);
    rstn = 1'b1;
    completeRun();
  end
  // Expected run is about 5 us; four times that means a hang
  initial begin
    #20000;
    failCount++;
    completeRun();
  end
endmodule // dpr_router_bench
